// [dv/sdc_checker.sv]
// Protocol assertions on the serial link between controller and device
`timescale 1ns/1ps
`default_nettype none
module sdc_checker (
    input wire logic clock,
    input wire logic reset,
    input wire logic chip_select_n,
    input wire logic sclk,
    input wire logic si,
    input wire logic so_data,
    input wire logic so_oe_n
);
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (reset);
    ////////////////////////////////////////////////////////////////////////
    csn_edge_a: assert property (
        $changed(chip_select_n) |-> !sclk)
        else $error("clock not low at a select edge");
    pulse_gate_a: assert property (
        $rose(sclk) |-> !chip_select_n)
        else $error("clock pulse outside a frame");
    lead_time_a: assert property (
        $fell(chip_select_n) |-> !sclk ##[10:12] $rose(sclk))
        else $error("lead time before first pulse wrong");
    high_time_a: assert property (
        $rose(sclk) |-> sclk[*8] ##1 !sclk)
        else $error("clock high phase not eight cycles");
    si_hold_a: assert property (
        sclk && $past(sclk) |-> $stable(si))
        else $error("input data moved while clock high");
    so_release_a: assert property (
        chip_select_n[*5] |-> so_oe_n)
        else $error("output driven while deselected");
    so_drive_a: assert property (
        !chip_select_n[*5] |-> !so_oe_n)
        else $error("output not driven inside a frame");
    oe_follow_a: assert property (
        $changed(so_oe_n) |-> so_oe_n == chip_select_n)
        else $error("output enable moved against select");
    // Data may only move after a rising clock, never while clock is low
    so_launch_a: assert property (
        !so_oe_n && !$past(so_oe_n) && !$past(so_oe_n, 2) &&
        !$past(chip_select_n) && $changed(so_data) |-> sclk)
        else $error("output data moved with clock low");
endmodule // sdc_checker
`default_nettype wire

// [dv/tb.sv]
// Bench joining controller and device ends over the serial link
`timescale 1ns/1ps
`include "sdc_cfg.svh"
`default_nettype none
module tb;
    import sdc_pkg::*;
    logic clock, reset, wr, rd, ch1_on, ch3_on, wdt, ro_n, wd_off;
    logic ch2_on, ch4_on, ch5_on, pdir, dread, wto_m;
    logic [1:0] thr_sel, load_sel;
    logic [6:0] ctl;
    logic [7:0] addr;
    logic [12:0] fault_cond, diag_flags, cmd_m, diag_m, w;
    logic [15:0] rx;
    logic [31:0] wdata, rdata, st, fst;
    sdc_addr_t pkind;
    int miscompares, total_checks, seed, i;
    sdc_if link();
    ////////////////////////////////////////////////////////////////////////
    sdc_host u_sdc_host (.clock(clock), .reset(reset), .link(link.host),
        .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata));
    sdc_dev u_sdc_dev (.clock(clock), .reset(reset), .link(link.dev),
        .fault_cond(fault_cond), .ch1_on_state(ch1_on),
        .ch3_on_state(ch3_on), .watchdog_timeout(wdt),
        .reset_output_n(ro_n), .watchdog_off_pin(wd_off),
        .ch2_on_ctrl(ch2_on), .ch4_on_ctrl(ch4_on), .ch5_on_ctrl(ch5_on),
        .vrs_threshold_sel(thr_sel), .vrs_load_sel(load_sel),
        .diag_flags(diag_flags));
    sdc_checker u_sdc_checker (.clock(clock), .reset(reset),
        .chip_select_n(link.chip_select_n), .sclk(link.sclk), .si(link.si),
        .so_data(link.so_data), .so_oe_n(link.so_oe_n));
    initial begin
        clock = 1'b0;
        forever #10 clock = ~clock;
    end
    ////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic bus(input logic w, input logic [7:0] a,
        input logic [31:0] d);
        @(posedge clock);
        wr <= w;
        rd <= ~w;
        addr <= a;
        wdata <= d;
        @(posedge clock);
        wr <= 1'b0;
        rd <= 1'b0;
        @(posedge clock);
        st = rdata;
    endtask
    // Polls busy under a bound so a stuck controller cannot hang the run
    task automatic frame(input logic [15:0] word);
        int n;
        bus(1'b1, `SDC_HOST_TX, {16'h0000, word});
        st = 32'h1;
        for (n = 0; n < 2000 && st[0] !== 1'b0; n++) begin
            bus(1'b0, `SDC_HOST_STAT, 32'h0);
        end
        fst = st;
        check(fst[1:0], 2'b10);
        bus(1'b0, `SDC_HOST_RX, 32'h0);
        rx = st[15:0];
    endtask
    function automatic logic [12:0] stat_m();
        return {wd_off, wto_m, 6'h00, cmd_m[2] & ~diag_m[11],
            cmd_m[1] & ~diag_m[9], ch3_on, cmd_m[0], ch1_on};
    endfunction
    function automatic logic [15:0] expect_m();
        logic [12:0] d;
        d = pkind == SDC_SEL_CMD ? cmd_m :
            pkind == SDC_SEL_DIAG ? diag_m : stat_m();
        return {pdir, pkind, d};
    endfunction
    // One frame against the model; the reply belongs to the previous frame
    task automatic step(input logic [15:0] word, input logic bad);
        frame(word);
        if (!bad) check(rx, expect_m());
        check(fst[2], |diag_m);
        if (pkind == SDC_SEL_DIAG) begin
            diag_m = diag_m & (13'h0a00 | fault_cond);
            dread = 1'b1;
        end
        if (pkind == SDC_SEL_STAT) wto_m = 1'b0;
        pdir = 1'b0;
        pkind = SDC_SEL_DIAG;
        if (!bad && (word[15:13] == 3'b100 ||
            (!word[15] && word[14:13] != 2'b11))) begin
            pdir = word[15];
            pkind = sdc_addr_t'(word[14:13]);
        end
        if (!bad && word[15:13] == 3'b100) begin
            cmd_m = word[12:0] & `SDC_CMD_WMASK;
            if (dread) diag_m = diag_m & ~13'h0a00;
            dread = 1'b0;
        end
        ctl = {thr_sel, load_sel, ch5_on, ch4_on, ch2_on};
        check(ctl, {cmd_m[12:9], cmd_m[2:0]});
        check(diag_flags, diag_m);
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        reset = 1'b1;
        {wr, rd, wdt, ro_n, addr, wdata} = {4'h1, 8'h00, 32'h0};
        {fault_cond, cmd_m, diag_m} = 39'h0;
        {pdir, dread, wto_m} = 3'h0;
        pkind = SDC_SEL_CMD;
        seed = 90582;
        {ch1_on, ch3_on, wd_off} = 3'($random(seed));
        repeat (8) @(posedge clock);
        check({link.so_oe_n, link.so_data}, 2'b00);
        reset <= 1'b0;
        repeat (4) @(posedge clock);
        ctl = {thr_sel, load_sel, ch5_on, ch4_on, ch2_on};
        check({ctl, diag_flags}, 20'h0);
        check(link.so_oe_n, 1'b1);
        $display("test reset done");
        for (i = 0; i < 4; i++) begin
            w = 13'($random(seed));
            w[12:9] = {i[1:0], ~i[1:0]};
            step({1'b1, SDC_SEL_CMD, w}, 1'b0);
        end
        $display("test command codes done");
        for (i = 0; i < 8; i++) step({i[2:0], 13'($random(seed))}, 1'b0);
        $display("test access table done");
        @(posedge clock);
        fault_cond <= 13'($random(seed)) | 13'h0a00;
        repeat (4) @(posedge clock);
        diag_m = diag_m | fault_cond;
        step({1'b0, SDC_SEL_DIAG, 13'h0000}, 1'b0);
        @(posedge clock);
        fault_cond <= 13'h0000;
        @(posedge clock);
        step({1'b0, SDC_SEL_STAT, 13'h0000}, 1'b0);
        step({1'b1, SDC_SEL_CMD, 13'h1fff}, 1'b0);
        step({1'b0, SDC_SEL_STAT, 13'h0000}, 1'b0);
        $display("test fault flags done");
        for (i = 15; i < 18; i += 2) begin
            bus(1'b1, `SDC_HOST_LEN, i);
            bus(1'b0, `SDC_HOST_LEN, 32'h0);
            check(st, i);
            step({1'b1, SDC_SEL_CMD, 13'h0000}, 1'b1);
        end
        bus(1'b1, `SDC_HOST_LEN, 32'd16);
        step({1'b0, SDC_SEL_CMD, 13'h0000}, 1'b0);
        $display("test frame length done");
        @(posedge clock);
        wdt <= 1'b1;
        ro_n <= 1'b0;
        fault_cond <= 13'h0001;
        @(posedge clock);
        wdt <= 1'b0;
        fault_cond <= 13'h0000;
        diag_m = diag_m | 13'h0001;
        wto_m = 1'b1;
        frame({1'b1, SDC_SEL_CMD, 13'h0000});
        check(rx, {16{|diag_m}});
        check(fst[2], |diag_m);
        @(posedge clock);
        ro_n <= 1'b1;
        pkind = SDC_SEL_STAT;
        pdir = 1'b0;
        step({1'b0, SDC_SEL_CMD, 13'h0000}, 1'b0);
        $display("test watchdog done");
        for (i = 0; i < 10; i++) step(16'($random(seed)), 1'b0);
        $display("test random frames done");
        give_verdict();
    end
    initial begin
        repeat (60000) @(posedge clock);
        miscompares++;
        give_verdict();
    end
endmodule // tb
`default_nettype wire

// [src/sdc_cfg.svh]
// Constants for the serial diagnosis and control link
`ifndef SDC_CFG_SVH
`define SDC_CFG_SVH
`define SDC_FRAME_BITS 16
`define SDC_DIR_BIT 15
`define SDC_ADDR_HI 14
`define SDC_ADDR_LO 13
`define SDC_DATA_W 13
`define SDC_THR_HI 12
`define SDC_THR_LO 11
`define SDC_LOAD_HI 10
`define SDC_LOAD_LO 9
`define SDC_CH2_BIT 0
`define SDC_CH4_BIT 1
`define SDC_CH5_BIT 2
`define SDC_CMD_RESET 13'h0000
`define SDC_CMD_WMASK 13'h1e07
`define SDC_DIAG_RESET 13'h0000
`define SDC_DIAG_RDCLR 13'h15ff
`define SDC_DIAG_OC45 13'h0a00
`define SDC_CH2_OVERCURRENT_FLAG_BIT 3
`define SDC_CH4_OVERCURRENT_FLAG_BIT 9
`define SDC_CH5_OVERCURRENT_FLAG_BIT 11
`define SDC_WATCHDOG_EXPIRED_FLAG_BIT 11
`define SDC_WD_OFF_BIT 12
`define SDC_HOST_TX 8'h00
`define SDC_HOST_RX 8'h04
`define SDC_HOST_STAT 8'h08
`define SDC_HOST_LEN 8'h0c
`define SDC_CLK_NS 20
`define SDC_HALF_NS 160
`define SDC_LEAD_NS 210
`define SDC_LAG_NS 75
`define SDC_GAP_NS 550
`define SDC_HALF_CYC (`SDC_HALF_NS / `SDC_CLK_NS)
`define SDC_LEAD_CYC ((`SDC_LEAD_NS + `SDC_CLK_NS - 1) / `SDC_CLK_NS)
`define SDC_LAG_CYC ((`SDC_LAG_NS + `SDC_CLK_NS - 1) / `SDC_CLK_NS)
`define SDC_GAP_CYC ((`SDC_GAP_NS + `SDC_CLK_NS - 1) / `SDC_CLK_NS)
`endif

// [src/sdc_dev.sv]
// Device end: 16-bit serial slave with command, diagnosis and status words
//
// Local design decisions: strobed register access and the placing of the registers.
`timescale 1ns/1ps
`include "sdc_cfg.svh"
`default_nettype none
module sdc_dev (
    input wire logic clock,
    input wire logic reset,
    sdc_if.dev link,
    input wire logic [`SDC_DATA_W-1:0] fault_cond,
    input wire logic ch1_on_state,
    input wire logic ch3_on_state,
    input wire logic watchdog_timeout,
    input wire logic reset_output_n,
    input wire logic watchdog_off_pin,
    output logic ch2_on_ctrl,
    output logic ch4_on_ctrl,
    output logic ch5_on_ctrl,
    output logic [1:0] vrs_threshold_sel,
    output logic [1:0] vrs_load_sel,
    output logic [`SDC_DATA_W-1:0] diag_flags
);
    import sdc_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    logic [3:0] pins_s;
    logic csn_s;
    logic sclk_s;
    logic si_s;
    logic watchdog_off_flag;
    logic csn_prev_q;
    logic sclk_prev_q;
    logic nro_prev_q;

    sdc_sync #(.WIDTH(4), .INIT(4'h8)) u_sync (
        .clock(clock),
        .reset(reset),
        .din({link.chip_select_n, link.sclk, link.si, watchdog_off_pin}),
        .dout(pins_s)
    );
    assign {csn_s, sclk_s, si_s, watchdog_off_flag} = pins_s;

    always_ff @(posedge clock) begin
        if (reset) begin
            csn_prev_q <= 1'b1;
            sclk_prev_q <= 1'b0;
            nro_prev_q <= 1'b1;
        end else begin
            csn_prev_q <= csn_s;
            sclk_prev_q <= sclk_s;
            nro_prev_q <= reset_output_n;
        end
    end

    logic in_frame;
    logic csn_fall;
    logic csn_rise;
    logic sclk_rise;
    logic sclk_fall;
    logic wd_rst;
    logic nro_rise;
    // Edges count only inside a frame, so a busy clock while deselected
    // leaves the shifters untouched
    assign in_frame = !csn_s && !csn_prev_q;
    assign csn_fall = csn_prev_q && !csn_s;
    assign csn_rise = !csn_prev_q && csn_s;
    assign sclk_rise = in_frame && sclk_s && !sclk_prev_q;
    assign sclk_fall = in_frame && !sclk_s && sclk_prev_q;
    assign wd_rst = !reset_output_n;
    assign nro_rise = reset_output_n && !nro_prev_q;

    ////////////////////////////////////////////////////////////////////////
    logic [`SDC_FRAME_BITS-1:0] rx_q;
    logic [`SDC_FRAME_BITS-1:0] tx_q;
    logic [4:0] cnt_q;

    always_ff @(posedge clock) begin
        if (reset) begin
            rx_q <= '0;
            cnt_q <= 5'h00;
        end else if (csn_fall) begin
            cnt_q <= 5'h00;
        end else if (sclk_fall) begin
            rx_q <= {rx_q[`SDC_FRAME_BITS-2:0], si_s};
            if (cnt_q != 5'h1f) begin
                cnt_q <= cnt_q + 5'h01;
            end
        end
    end

    logic rx_dir;
    sdc_addr_t rx_addr;
    logic len_ok;
    logic cmd_ok;
    logic exec;
    assign rx_dir = rx_q[`SDC_DIR_BIT];
    assign rx_addr = sdc_addr_t'(rx_q[`SDC_ADDR_HI:`SDC_ADDR_LO]);
    assign len_ok = cnt_q == 5'(`SDC_FRAME_BITS);
    assign cmd_ok = rx_dir ? (rx_addr == SDC_SEL_CMD)
                           : (rx_addr != SDC_SEL_NONE);
    assign exec = csn_rise && !wd_rst && len_ok && cmd_ok;

    ////////////////////////////////////////////////////////////////////////
    logic rep_dir_q;
    sdc_addr_t rep_addr_q;

    always_ff @(posedge clock) begin
        if (reset) begin
            rep_dir_q <= 1'b0;
            rep_addr_q <= SDC_SEL_CMD;
        end else if (nro_rise) begin
            rep_dir_q <= 1'b0;
            rep_addr_q <= SDC_SEL_STAT;
        end else if (exec) begin
            rep_dir_q <= rx_dir;
            rep_addr_q <= rx_addr;
        end else if (csn_rise && !wd_rst) begin
            rep_dir_q <= 1'b0;
            rep_addr_q <= SDC_SEL_DIAG;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    logic [`SDC_DATA_W-1:0] cmd_q;
    logic [`SDC_DATA_W-1:0] diag_q;
    logic watchdog_expired_flag_q;
    logic oc45_armed_q;
    logic cmd_write;
    logic diag_shown;
    logic stat_shown;

    assign cmd_write = exec && rx_dir;
    // A flag other than bits 9 and 11 is cleared when it is actually shifted out, not when the
    // read is requested, so the reader never loses a pending fault
    assign diag_shown = csn_fall && !wd_rst && rep_addr_q == SDC_SEL_DIAG;
    assign stat_shown = csn_fall && !wd_rst && rep_addr_q == SDC_SEL_STAT;

    always_ff @(posedge clock) begin
        if (reset) begin
            cmd_q <= `SDC_CMD_RESET;
        end else if (cmd_write) begin
            cmd_q <= rx_q[`SDC_DATA_W-1:0] & `SDC_CMD_WMASK;
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            oc45_armed_q <= 1'b0;
        end else if (diag_shown) begin
            oc45_armed_q <= 1'b1;
        end else if (cmd_write) begin
            oc45_armed_q <= 1'b0;
        end
    end

    logic [`SDC_DATA_W-1:0] diag_clr;
    always_comb begin
        diag_clr = '0;
        if (diag_shown) begin
            diag_clr = diag_clr | `SDC_DIAG_RDCLR;
        end
        if (cmd_write && oc45_armed_q) begin
            diag_clr = diag_clr | `SDC_DIAG_OC45;
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            diag_q <= `SDC_DIAG_RESET;
        end else begin
            // A live condition always sets, even in the clearing cycle
            diag_q <= (diag_q & ~diag_clr) | fault_cond;
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            watchdog_expired_flag_q <= 1'b0;
        end else if (watchdog_timeout) begin
            watchdog_expired_flag_q <= 1'b1;
        end else if (stat_shown) begin
            watchdog_expired_flag_q <= 1'b0;
        end
    end

    logic [`SDC_DATA_W-1:0] stat_w;
    always_comb begin
        stat_w = '0;
        stat_w[0] = ch1_on_state;
        stat_w[1] = cmd_q[`SDC_CH2_BIT];
        stat_w[2] = ch3_on_state;
        stat_w[3] = cmd_q[`SDC_CH4_BIT] && !diag_q[`SDC_CH4_OVERCURRENT_FLAG_BIT];
        stat_w[4] = cmd_q[`SDC_CH5_BIT] && !diag_q[`SDC_CH5_OVERCURRENT_FLAG_BIT];
        stat_w[`SDC_WATCHDOG_EXPIRED_FLAG_BIT] = watchdog_expired_flag_q;
        stat_w[`SDC_WD_OFF_BIT] = watchdog_off_flag;
    end

    logic [`SDC_DATA_W-1:0] rep_data;
    always_comb begin
        case (rep_addr_q)
            SDC_SEL_CMD: rep_data = cmd_q;
            SDC_SEL_DIAG: rep_data = diag_q;
            SDC_SEL_STAT: rep_data = stat_w;
            default: rep_data = '0;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    logic so_q;
    logic so_oe_n_q;

    always_ff @(posedge clock) begin
        if (reset) begin
            tx_q <= '0;
        end else if (csn_fall && !wd_rst) begin
            tx_q <= {rep_dir_q, rep_addr_q, rep_data};
        end else if (sclk_rise && !wd_rst) begin
            tx_q <= {tx_q[`SDC_FRAME_BITS-2:0], 1'b0};
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            so_q <= 1'b0;
            so_oe_n_q <= 1'b0;
        end else begin
            so_oe_n_q <= csn_s;
            if (csn_fall || (wd_rst && !csn_s)) begin
                so_q <= |diag_q;
            end else if (sclk_rise) begin
                so_q <= tx_q[`SDC_FRAME_BITS-1];
            end
        end
    end

    assign link.so_data = so_q;
    assign link.so_oe_n = so_oe_n_q;
    assign ch2_on_ctrl = cmd_q[`SDC_CH2_BIT];
    assign ch4_on_ctrl = cmd_q[`SDC_CH4_BIT];
    assign ch5_on_ctrl = cmd_q[`SDC_CH5_BIT];
    assign vrs_threshold_sel = cmd_q[`SDC_THR_HI:`SDC_THR_LO];
    assign vrs_load_sel = cmd_q[`SDC_LOAD_HI:`SDC_LOAD_LO];
    assign diag_flags = diag_q;
endmodule // sdc_dev
`default_nettype wire

// [src/sdc_host.sv]
// Controller end: serial master driven by a simple register port
`timescale 1ns/1ps
`include "sdc_cfg.svh"
`default_nettype none
module sdc_host #(
    parameter int HALF_CYC = `SDC_HALF_CYC,
    parameter int LEAD_CYC = `SDC_LEAD_CYC,
    parameter int LAG_CYC = `SDC_LAG_CYC,
    parameter int GAP_CYC = `SDC_GAP_CYC
) (
    input wire logic clock,
    input wire logic reset,
    sdc_if.host link,
    input wire logic [7:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [31:0] rdata
);
    import sdc_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    logic so_s;
    sdc_sync #(.WIDTH(1), .INIT(1'b0)) u_sync (
        .clock(clock),
        .reset(reset),
        .din(link.so_data),
        .dout(so_s)
    );

    sdc_host_state_t state_q;
    logic [7:0] timer_q;
    logic [4:0] pulses_q;
    logic [4:0] len_q;
    logic [15:0] tx_q;
    logic [15:0] rx_q;
    logic [15:0] rxd_q;
    logic flag_q;
    logic done_q;
    logic csn_q;
    logic sclk_q;
    logic si_q;
    logic start;
    logic tdone;
    logic finish;

    assign start = wr && addr == `SDC_HOST_TX && state_q == SDC_H_IDLE;
    assign tdone = timer_q == 8'h00;
    assign finish = state_q == SDC_H_GAP && tdone;

    ////////////////////////////////////////////////////////////////////////
    // Clock stays low at both select edges; length may be set short on
    // purpose to provoke a rejected frame
    always_ff @(posedge clock) begin
        if (reset) begin
            state_q <= SDC_H_IDLE;
            timer_q <= 8'h00;
            pulses_q <= 5'h00;
            csn_q <= 1'b1;
            sclk_q <= 1'b0;
            si_q <= 1'b0;
            tx_q <= '0;
            rx_q <= '0;
            flag_q <= 1'b0;
        end else begin
            if (!tdone) begin
                timer_q <= timer_q - 8'h01;
            end
            case (state_q)
                SDC_H_IDLE: if (start) begin
                    tx_q <= wdata[15:0];
                    si_q <= wdata[15];
                    csn_q <= 1'b0;
                    pulses_q <= 5'h00;
                    timer_q <= 8'(LEAD_CYC - 1);
                    state_q <= SDC_H_LEAD;
                end
                SDC_H_LEAD: if (tdone) begin
                    flag_q <= so_s;
                    timer_q <= 8'(HALF_CYC - 1);
                    if (len_q == 5'h00) begin
                        state_q <= SDC_H_LAG;
                    end else begin
                        sclk_q <= 1'b1;
                        pulses_q <= 5'h01;
                        state_q <= SDC_H_HIGH;
                    end
                end
                SDC_H_HIGH: if (tdone) begin
                    sclk_q <= 1'b0;
                    rx_q <= {rx_q[14:0], so_s};
                    tx_q <= {tx_q[14:0], 1'b0};
                    timer_q <= (pulses_q == len_q) ? 8'(LAG_CYC - 1)
                                                   : 8'(HALF_CYC - 1);
                    state_q <= (pulses_q == len_q) ? SDC_H_LAG : SDC_H_LOW;
                end
                SDC_H_LOW: if (tdone) begin
                    sclk_q <= 1'b1;
                    si_q <= tx_q[15];
                    pulses_q <= pulses_q + 5'h01;
                    timer_q <= 8'(HALF_CYC - 1);
                    state_q <= SDC_H_HIGH;
                end
                SDC_H_LAG: if (tdone) begin
                    csn_q <= 1'b1;
                    timer_q <= 8'(GAP_CYC - 1);
                    state_q <= SDC_H_GAP;
                end
                SDC_H_GAP: if (tdone) begin
                    state_q <= SDC_H_IDLE;
                end
                default: state_q <= SDC_H_IDLE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clock) begin
        if (reset) begin
            len_q <= 5'(`SDC_FRAME_BITS);
        end else if (wr && addr == `SDC_HOST_LEN) begin
            len_q <= wdata[4:0];
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            rxd_q <= '0;
            done_q <= 1'b0;
        end else begin
            if (finish) begin
                rxd_q <= rx_q;
                done_q <= 1'b1;
            end else if (rd && addr == `SDC_HOST_STAT) begin
                done_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            rdata <= '0;
        end else if (rd) begin
            case (addr)
                `SDC_HOST_RX: rdata <= {16'h0000, rxd_q};
                `SDC_HOST_STAT: rdata <= {29'h0, flag_q, done_q,
                                          state_q != SDC_H_IDLE};
                `SDC_HOST_LEN: rdata <= {27'h0, len_q};
                default: rdata <= '0;
            endcase
        end else begin
            rdata <= '0;
        end
    end

    assign link.chip_select_n = csn_q;
    assign link.sclk = sclk_q;
    assign link.si = si_q;
endmodule // sdc_host
`default_nettype wire

// [src/sdc_if.sv]
// Four-wire serial link between controller and device
`timescale 1ns/1ps
`default_nettype none
interface sdc_if;
    logic chip_select_n;
    logic sclk;
    logic si;
    logic so_data;
    logic so_oe_n;
    modport dev (
        input chip_select_n,
        input sclk,
        input si,
        output so_data,
        output so_oe_n
    );
    modport host (
        output chip_select_n,
        output sclk,
        output si,
        input so_data,
        input so_oe_n
    );
endinterface
`default_nettype wire

// [src/sdc_pkg.sv]
// Types shared by both ends of the serial diagnosis and control link
`default_nettype none
package sdc_pkg;
    typedef enum logic [1:0] {
        SDC_SEL_CMD = 2'h0,
        SDC_SEL_DIAG = 2'h1,
        SDC_SEL_STAT = 2'h2,
        SDC_SEL_NONE = 2'h3
    } sdc_addr_t;
    typedef enum logic [5:0] {
        SDC_H_IDLE = 6'h01,
        SDC_H_LEAD = 6'h02,
        SDC_H_HIGH = 6'h04,
        SDC_H_LOW = 6'h08,
        SDC_H_LAG = 6'h10,
        SDC_H_GAP = 6'h20
    } sdc_host_state_t;
endpackage
`default_nettype wire

// [src/sdc_sync.sv]
// Two-stage synchroniser for inputs from outside the clock domain
`timescale 1ns/1ps
`default_nettype none
module sdc_sync #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] INIT = '0
) (
    input wire logic clock,
    input wire logic reset,
    input wire logic [WIDTH-1:0] din,
    output logic [WIDTH-1:0] dout
);
    logic [WIDTH-1:0] meta_q;
    always_ff @(posedge clock) begin
        if (reset) begin
            meta_q <= INIT;
            dout <= INIT;
        end else begin
            meta_q <= din;
            dout <= meta_q;
        end
    end
endmodule // sdc_sync
`default_nettype wire
